// >>> txpp_regs.svh
// Constants for the transmit FIFO and parallel port control block
`ifndef TXPP_REGS_SVH
`define TXPP_REGS_SVH

// Nominal clock rates in kHz, normal and error-correction rate
`define TXPP_PCLK_NORM_KHZ 622080
`define TXPP_PCLK_FEC_KHZ 666510
`define TXPP_AUX_NORM_KHZ 155520
`define TXPP_AUX_FEC_KHZ 166630

// Parallel clock half periods per auxiliary clock half period
`define TXPP_AUX_TICKS (`TXPP_PCLK_NORM_KHZ / `TXPP_AUX_NORM_KHZ)

// Flush timing in parallel clock output cycles
`define TXPP_RST_HOLD_MIN 2
`define TXPP_FLUSH_MIN 8
`define TXPP_FLUSH_MAX 10
`define TXPP_FLUSH_CYC ((`TXPP_FLUSH_MIN + `TXPP_FLUSH_MAX) / 2)

// Data path
`define TXPP_LANES 4
`define TXPP_FIFO_DEPTH 9

// Field positions in the pin synchroniser vector
`define TXPP_S_ZERO 0
`define TXPP_S_LOCK 1
`define TXPP_S_AUXDIS 2
`define TXPP_S_AUTO 3
`define TXPP_S_FRST 4
`define TXPP_S_DATA 5
`define TXPP_S_PCLK 9
`define TXPP_S_WIDTH 10

`endif

// >>> txpp_pkg.sv
// Types for the transmit FIFO and parallel port control block
`default_nettype none

package txpp_pkg;

    typedef enum logic [1:0] {
        TXPP_FL_IDLE = 2'h0,
        TXPP_FL_HOLD = 2'h1,
        TXPP_FL_COUNT = 2'h2,
        TXPP_FL_CENTRE = 2'h3
    } txpp_flush_t;

endpackage : txpp_pkg

`default_nettype wire

// >>> txpp_tick.sv
// Divider that issues a one-cycle enable pulse every DIV clocks
`timescale 1ns/10ps
`default_nettype none

module txpp_tick #(
    parameter int DIV = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    output logic tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic tick_q;
    logic tick_d;

    always_comb begin
        tick_d = (cnt_q == CW'(DIV - 1));
        cnt_d = tick_d ? '0 : cnt_q + 1'b1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

endmodule : txpp_tick

`default_nettype wire

// >>> txpp_fifo.sv
// Elastic FIFO with registered read data and a synchronous flush
`timescale 1ns/10ps
`default_nettype none

module txpp_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] wr_d;
    logic [AW-1:0] rd_q;
    logic [AW-1:0] rd_d;
    logic [LW-1:0] level_q;
    logic [LW-1:0] level_d;
    logic [WIDTH-1:0] data_q;
    logic [WIDTH-1:0] data_d;
    logic push;
    logic pop;

    always_comb begin
        in_ready = (level_q != LW'(DEPTH));
        out_valid = (level_q != '0);
        push = in_valid & in_ready;
        pop = out_valid & out_ready;
        wr_d = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
        rd_d = pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
        level_d = level_q + LW'(push) - LW'(pop);
        data_d = pop ? mem_q[rd_q] : data_q;
        if (flush) begin
            wr_d = '0;
            rd_d = '0;
            level_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (push && !flush) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            level_q <= '0;
            data_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            level_q <= level_d;
            data_q <= data_d;
        end
    end

    assign out_data = data_q;
    assign level = level_q;

    a_fifo_level_bound: assert property (@(posedge clk) disable iff (!rst_n)
        level_q <= LW'(DEPTH)) else $error("FIFO level above depth");

    a_fifo_full_refuse: assert property (@(posedge clk) disable iff (!rst_n)
        (level_q == LW'(DEPTH)) && in_valid && !out_ready && !flush |=> level_q == LW'(DEPTH))
        else $error("FIFO accepted a word while full");

endmodule : txpp_fifo

`default_nettype wire

// >>> txpp_ctrl.sv
// Transmit elastic FIFO control and receive parallel output of the transceiver
`timescale 1ns/10ps
`default_nettype none
`include "txpp_regs.svh"

module txpp_ctrl
    import txpp_pkg::*;
#(
    parameter int PCLK_DIV = 2,
    parameter int REF_DIV = 2,
    parameter int FIFO_DEPTH = `TXPP_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tx_parallel_clock_in,
    input wire logic [`TXPP_LANES-1:0] tx_parallel_data,
    input wire logic fifo_reset,
    input wire logic tx_fifo_auto_recover,
    input wire logic aux_tx_clock_disable,
    input wire logic multiplier_locked,
    input wire logic rx_bit,
    input wire logic rx_bit_valid,
    input wire logic rx_data_force_zero,
    output logic tx_parallel_clock_out,
    output logic aux_tx_clock_out,
    output logic tx_multiplier_lock,
    output logic tx_fifo_overflow,
    output logic [`TXPP_LANES-1:0] tx_serial_nibble,
    output logic tx_serial_valid,
    output logic [`TXPP_LANES-1:0] rx_parallel_data,
    output logic rx_parallel_clock_out
);
    localparam int LW = $clog2(FIFO_DEPTH + 1);

    // Pin synchroniser
    logic [`TXPP_S_WIDTH-1:0] pins;
    logic [`TXPP_S_WIDTH-1:0] sy1_q;
    logic [`TXPP_S_WIDTH-1:0] sy2_q;
    logic pclk_in_s;
    logic [`TXPP_LANES-1:0] data_s;
    logic frst_s;
    logic auto_s;
    logic auxdis_s;
    logic lock_s;
    logic zero_s;

    // Transmit side state
    logic pclk_prev_q;
    logic pclk_prev_d;
    logic pclk_q;
    logic pclk_d;
    logic aux_q;
    logic aux_d;
    logic [1:0] aux_cnt_q;
    logic [1:0] aux_cnt_d;
    logic lock_q;
    logic lock_d;
    logic ovf_q;
    logic ovf_d;
    txpp_flush_t fl_q;
    txpp_flush_t fl_d;
    logic [3:0] fl_cnt_q;
    logic [3:0] fl_cnt_d;
    logic pop_q;
    logic pop_d;
    logic [`TXPP_LANES-1:0] nib_q;
    logic [`TXPP_LANES-1:0] nib_d;
    logic val_q;
    logic val_d;

    // Receive side state
    logic [`TXPP_LANES-1:0] sh_q;
    logic [`TXPP_LANES-1:0] sh_d;
    logic [1:0] bit_cnt_q;
    logic [1:0] bit_cnt_d;
    logic [`TXPP_LANES-1:0] rxd_q;
    logic [`TXPP_LANES-1:0] rxd_d;
    logic rxclk_q;
    logic rxclk_d;
    logic [`TXPP_LANES-1:0] rx_group;

    // Combinational helpers
    logic pclk_tick;
    logic ref_tick;
    logic pclk_rise;
    logic wr_stb;
    logic flushing;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [`TXPP_LANES-1:0] fifo_out_data;
    logic [LW-1:0] fifo_level;
    logic ovf_event;
    logic centred;

    txpp_tick #(
        .DIV(PCLK_DIV)
    ) u_pclk_tick (
        .clk(clk),
        .rst_n(rst_n),
        .tick(pclk_tick)
    );

    txpp_tick #(
        .DIV(REF_DIV)
    ) u_ref_tick (
        .clk(clk),
        .rst_n(rst_n),
        .tick(ref_tick)
    );

    txpp_fifo #(
        .WIDTH(`TXPP_LANES),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .flush(flushing),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(data_s),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    always_comb begin
        pins = {tx_parallel_clock_in, tx_parallel_data, fifo_reset, tx_fifo_auto_recover,
                aux_tx_clock_disable, multiplier_locked, rx_data_force_zero};
        pclk_in_s = sy2_q[`TXPP_S_PCLK];
        data_s = sy2_q[`TXPP_S_DATA +: `TXPP_LANES];
        frst_s = sy2_q[`TXPP_S_FRST];
        auto_s = sy2_q[`TXPP_S_AUTO];
        auxdis_s = sy2_q[`TXPP_S_AUXDIS];
        lock_s = sy2_q[`TXPP_S_LOCK];
        zero_s = sy2_q[`TXPP_S_ZERO];
    end

    // Transmit clocks, lock status and FIFO write/read
    always_comb begin
        pclk_rise = pclk_tick & ~pclk_q;
        pclk_d = pclk_tick ? ~pclk_q : pclk_q;
        aux_cnt_d = pclk_tick ? aux_cnt_q + 2'h1 : aux_cnt_q;
        aux_d = aux_q;
        if (auxdis_s) begin
            aux_d = 1'b0;
        end else if (pclk_tick && aux_cnt_q == 2'(`TXPP_AUX_TICKS - 1)) begin
            aux_d = ~aux_q;
        end
        lock_d = lock_s;
        pclk_prev_d = pclk_in_s;
        wr_stb = pclk_in_s & ~pclk_prev_q;
        flushing = (fl_q == TXPP_FL_HOLD) || (fl_q == TXPP_FL_COUNT);
        fifo_in_valid = wr_stb & ~flushing;
        ovf_event = fifo_in_valid & ~fifo_in_ready;
        centred = (fifo_level >= LW'(FIFO_DEPTH / 2));
        fifo_out_ready = ref_tick & (fl_q == TXPP_FL_IDLE);
        pop_d = fifo_out_ready & fifo_out_valid;
        nib_d = pop_q ? fifo_out_data : nib_q;
        val_d = pop_q;
    end

    // Flush sequencer and overflow flag
    always_comb begin
        fl_d = fl_q;
        fl_cnt_d = fl_cnt_q;
        ovf_d = ovf_q | ovf_event;
        if (frst_s) begin
            fl_d = TXPP_FL_HOLD;
        end else begin
            unique case (fl_q)
                TXPP_FL_IDLE: begin
                    if (auto_s && (ovf_event || ovf_q)) begin
                        fl_d = TXPP_FL_COUNT;
                        fl_cnt_d = 4'h0;
                    end
                end
                TXPP_FL_HOLD: begin
                    fl_d = TXPP_FL_COUNT;
                    fl_cnt_d = 4'h0;
                end
                TXPP_FL_COUNT: begin
                    if (pclk_rise) begin
                        fl_cnt_d = fl_cnt_q + 4'h1;
                        if (fl_cnt_q == 4'(`TXPP_FLUSH_CYC - 1)) begin
                            fl_d = TXPP_FL_CENTRE;
                        end
                    end
                end
                TXPP_FL_CENTRE: begin
                    if (centred) begin
                        fl_d = TXPP_FL_IDLE;
                        ovf_d = ovf_event;
                    end
                end
            endcase
        end
    end

    // Receive demultiplexer, MSB first
    always_comb begin
        rx_group = {sh_q[`TXPP_LANES-2:0], rx_bit};
        sh_d = sh_q;
        bit_cnt_d = bit_cnt_q;
        rxd_d = rxd_q;
        rxclk_d = rxclk_q;
        if (rx_bit_valid) begin
            sh_d = rx_group;
            bit_cnt_d = bit_cnt_q + 2'h1;
            if (bit_cnt_q == 2'h3) begin
                rxd_d = rx_group;
                rxclk_d = 1'b1;
            end else if (bit_cnt_q == 2'h1) begin
                rxclk_d = 1'b0;
            end
        end
        if (zero_s) begin
            rxd_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sy1_q <= '0;
            sy2_q <= '0;
            pclk_prev_q <= 1'b0;
            pclk_q <= 1'b0;
            aux_q <= 1'b0;
            aux_cnt_q <= 2'h0;
            lock_q <= 1'b0;
            ovf_q <= 1'b0;
            fl_q <= TXPP_FL_HOLD;
            fl_cnt_q <= 4'h0;
            pop_q <= 1'b0;
            nib_q <= '0;
            val_q <= 1'b0;
            sh_q <= '0;
            bit_cnt_q <= 2'h0;
            rxd_q <= '0;
            rxclk_q <= 1'b0;
        end else begin
            sy1_q <= pins;
            sy2_q <= sy1_q;
            pclk_prev_q <= pclk_prev_d;
            pclk_q <= pclk_d;
            aux_q <= aux_d;
            aux_cnt_q <= aux_cnt_d;
            lock_q <= lock_d;
            ovf_q <= ovf_d;
            fl_q <= fl_d;
            fl_cnt_q <= fl_cnt_d;
            pop_q <= pop_d;
            nib_q <= nib_d;
            val_q <= val_d;
            sh_q <= sh_d;
            bit_cnt_q <= bit_cnt_d;
            rxd_q <= rxd_d;
            rxclk_q <= rxclk_d;
        end
    end

    assign tx_parallel_clock_out = pclk_q;
    assign aux_tx_clock_out = aux_q;
    assign tx_multiplier_lock = lock_q;
    assign tx_fifo_overflow = ovf_q;
    assign tx_serial_nibble = nib_q;
    assign tx_serial_valid = val_q;
    assign rx_parallel_data = rxd_q;
    assign rx_parallel_clock_out = rxclk_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_aux_toggle_phase: assert property ($changed(aux_q) && !$past(auxdis_s) |->
        aux_cnt_q == 2'h0) else $error("Auxiliary clock toggled off its divide phase");

    a_aux_stopped: assert property (auxdis_s |=> !aux_tx_clock_out)
        else $error("Auxiliary clock runs while disabled");

    a_lock_follows: assert property (##1 tx_multiplier_lock == $past(lock_s))
        else $error("Lock output does not follow multiplier lock");

    a_ovf_raised: assert property (ovf_event |=> tx_fifo_overflow)
        else $error("Overflow not flagged");

    a_flush_window: assert property ($fell(frst_s) && fl_q == TXPP_FL_HOLD |->
        (!frst_s && fl_q != TXPP_FL_CENTRE) [*3] ##[28:42] fl_q == TXPP_FL_CENTRE || frst_s)
        else $error("Flush did not finish in 8 to 10 parallel clocks");

    a_auto_flush: assert property (ovf_event && auto_s && !frst_s && fl_q == TXPP_FL_IDLE
        |=> fl_q == TXPP_FL_COUNT) else $error("Automatic flush not started");

    a_manual_only: assert property (ovf_event && !auto_s && !frst_s && fl_q == TXPP_FL_IDLE
        |=> fl_q == TXPP_FL_IDLE && tx_fifo_overflow)
        else $error("Flush started without auto recover");

    a_rx_msb_first: assert property (rx_bit_valid && bit_cnt_q == 2'h3 && !zero_s |=>
        rx_parallel_data == $past(rx_group) && $rose(rx_parallel_clock_out))
        else $error("Receive group not placed MSB first");

    a_rx_update_edge: assert property ($changed(rx_parallel_data) && !$past(zero_s) |->
        $rose(rx_parallel_clock_out)) else $error("Receive lanes changed off clock rise");

    a_rx_clk_phase: assert property ($rose(rx_parallel_clock_out) |-> bit_cnt_q == 2'h0)
        else $error("Receive clock rose mid group");

    a_rx_forced_zero: assert property (zero_s |=> rx_parallel_data == '0)
        else $error("Receive lanes not forced to zero");

    a_ovf_cleared: assert property (fl_q == TXPP_FL_CENTRE && centred && !frst_s && !ovf_event
        |=> !tx_fifo_overflow) else $error("Overflow not cleared after recentre");

endmodule : txpp_ctrl

`default_nettype wire

// >>> txpp_framer_model.sv
// Far-end framer model driving the transmit parallel clock and data pins
`timescale 1ns/10ps
`default_nettype none
`include "txpp_regs.svh"

module txpp_framer_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic slow,
    input wire logic pclk_ref,
    output logic pin_clk,
    output logic [`TXPP_LANES-1:0] pin_data
);
    logic ref_q = 1'b0;
    logic pin_q = 1'b0;
    logic gate_q = 1'b0;
    logic [1:0] slot_q = 2'h0;
    logic [`TXPP_LANES-1:0] data_q = 4'h0;
    logic fall;

    assign fall = ref_q & ~pclk_ref;
    assign pin_clk = pin_q;
    assign pin_data = data_q;

    // Gate changes only on a falling edge so every pin pulse is whole
    always @(posedge clk) begin
        if (!rst_n) begin
            ref_q <= 1'b0;
            pin_q <= 1'b0;
            gate_q <= 1'b0;
            slot_q <= 2'h0;
            data_q <= 4'h0;
        end else begin
            ref_q <= pclk_ref;
            pin_q <= gate_q & pclk_ref;
            if (fall) begin
                slot_q <= slot_q + 2'h1;
                gate_q <= run & (~slow | (slot_q == 2'h3));
                if (gate_q) begin
                    data_q <= data_q + 4'h1;
                end
            end
        end
    end
endmodule : txpp_framer_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench for the transmit FIFO and parallel port control block
`timescale 1ns/10ps
`default_nettype none
`include "txpp_regs.svh"

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic fifo_reset = 1'b0;
    logic auto_rec = 1'b0;
    logic aux_dis = 1'b0;
    logic locked = 1'b0;
    logic rx_bit = 1'b0;
    logic rx_bit_valid = 1'b0;
    logic force_zero = 1'b0;
    logic run = 1'b0;
    logic slow = 1'b1;
    logic use_aux = 1'b0;
    logic pin_clk;
    logic [3:0] pin_data;
    logic pclk_out, aux_out, lock_out, ovf, ser_valid, rx_clk;
    logic [3:0] ser_nib, rx_data, prev_nib;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    int pops = 0;
    int n, pc, ac;
    logic mon_on = 1'b0;
    logic have_prev = 1'b0;

    initial forever #5 clk = ~clk;

    txpp_ctrl #(.PCLK_DIV(2), .REF_DIV(8), .FIFO_DEPTH(9)) uut (
        .clk(clk), .rst_n(rst_n),
        .tx_parallel_clock_in(pin_clk), .tx_parallel_data(pin_data),
        .fifo_reset(fifo_reset), .tx_fifo_auto_recover(auto_rec),
        .aux_tx_clock_disable(aux_dis), .multiplier_locked(locked),
        .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .rx_data_force_zero(force_zero),
        .tx_parallel_clock_out(pclk_out), .aux_tx_clock_out(aux_out),
        .tx_multiplier_lock(lock_out), .tx_fifo_overflow(ovf),
        .tx_serial_nibble(ser_nib), .tx_serial_valid(ser_valid),
        .rx_parallel_data(rx_data), .rx_parallel_clock_out(rx_clk)
    );

    txpp_framer_model far_end (
        .clk(clk), .rst_n(rst_n), .run(run), .slow(slow),
        .pclk_ref(use_aux ? aux_out : pclk_out),
        .pin_clk(pin_clk), .pin_data(pin_data)
    );

    task report_and_stop;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    // Popped nibbles must come out in write order
    always @(negedge clk) begin
        if (mon_on && ser_valid === 1'b1) begin
            if (have_prev) `CHK(ser_nib, prev_nib + 4'h1)
            prev_nib = ser_nib;
            have_prev = 1'b1;
            pops++;
        end
    end

    task count_rises(input int len, output int p, output int a);
        logic lp, la;
        p = 0;
        a = 0;
        lp = pclk_out;
        la = aux_out;
        repeat (len) begin
            @(posedge clk);
            #1;
            if (pclk_out && !lp) p++;
            if (aux_out && !la) a++;
            lp = pclk_out;
            la = aux_out;
        end
    endtask : count_rises

    task wait_ovf(input logic lvl, input int lim, output int waited);
        waited = 0;
        while (ovf !== lvl && waited < lim) begin
            @(posedge clk);
            #1;
            waited++;
        end
        `CHK(ovf, lvl)
    endtask : wait_ovf

    task pulse_fifo_reset;
        @(posedge clk);
        fifo_reset <= 1'b1;
        repeat (10) @(posedge clk);
        fifo_reset <= 1'b0;
    endtask : pulse_fifo_reset

    task send_nibble(input logic [3:0] v, input logic [3:0] exp);
        for (int i = 3; i >= 0; i--) begin
            @(posedge clk);
            rx_bit_valid <= 1'b1;
            rx_bit <= v[i];
        end
        @(posedge clk);
        rx_bit_valid <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK(rx_data, exp)
        `CHK(rx_clk, 1'b1)
    endtask : send_nibble

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        `CHK({ovf, ser_valid, rx_data}, 6'h00)
        count_rises(64, pc, ac);
        `CHK(pc, 16)
        `CHK(ac, 4)
        @(posedge clk);
        aux_dis <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        count_rises(64, pc, ac);
        `CHK(ac, 0)
        `CHK(aux_out, 1'b0)
        @(posedge clk);
        aux_dis <= 1'b0;
        locked <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        `CHK(lock_out, 1'b1)
        @(posedge clk);
        locked <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        `CHK(lock_out, 1'b0)
        // Power-up flush, then slow writes that reads keep up with
        pulse_fifo_reset();
        run <= 1'b1;
        mon_on <= 1'b1;
        repeat (300) @(posedge clk);
        `CHK(pops > 8, 1'b1)
        `CHK(ovf, 1'b0)
        // Far end times its writes from the auxiliary clock instead
        run <= 1'b0;
        repeat (10) @(posedge clk);
        use_aux <= 1'b1;
        slow <= 1'b0;
        n = pops;
        @(posedge clk);
        run <= 1'b1;
        repeat (200) @(posedge clk);
        mon_on <= 1'b0;
        `CHK(pops > n + 8, 1'b1)
        `CHK(ovf, 1'b0)
        // Fast writes fill the FIFO until it refuses
        use_aux <= 1'b0;
        wait_ovf(1'b1, 300, n);
        run <= 1'b0;
        repeat (150) @(posedge clk);
        pc = 0;
        repeat (40) begin
            @(posedge clk);
            #1;
            if (ser_valid === 1'b1) pc++;
        end
        `CHK(pc, 0)
        `CHK(ovf, 1'b1)
        run <= 1'b1;
        pulse_fifo_reset();
        wait_ovf(1'b0, 150, n);
        `CHK(n >= 32, 1'b1)
        `CHK(n <= 90, 1'b1)
        // Automatic recovery without any manual reset
        @(posedge clk);
        auto_rec <= 1'b1;
        wait_ovf(1'b1, 300, n);
        wait_ovf(1'b0, 150, n);
        @(posedge clk);
        auto_rec <= 1'b0;
        run <= 1'b0;
        for (int k = 0; k < 16; k++) send_nibble(k[3:0], k[3:0]);
        @(posedge clk);
        force_zero <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        `CHK(rx_data, 4'h0)
        send_nibble(4'hA, 4'h0);
        @(posedge clk);
        force_zero <= 1'b0;
        repeat (4) @(posedge clk);
        send_nibble(4'h5, 4'h5);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
